/* File: pkg/port_c_pkg.sv */
// Register map, reset values and field positions of the eight-bit port C block.
package port_c_pkg;

  // ==========================================================================
  // Register indices; the Avalon word address equals the index (byte address is four times it).
  // ==========================================================================
  localparam int ADDR_W = 32;
  localparam logic [ADDR_W-1:0] PORT_C_DATA_IDX = 32'hFFFFF058;
  localparam logic [ADDR_W-1:0] PORT_C_DIRECTION_IDX = 32'hFFFFF05A;
  localparam logic [ADDR_W-1:0] PORT_C_FUNCTION_SELECT_IDX = 32'hFFFFF05B;

  // ==========================================================================
  // Widths and reset values.
  // ==========================================================================
  localparam int PORT_W = 8;
  localparam int BUS_W = 32;
  localparam logic [7:0] DATA_LATCH_RESET = 8'hFF;
  localparam logic [7:0] DIRECTION_RESET = 8'h00;
  localparam logic [7:0] FUNCTION_SELECT_RESET = 8'h00;
  localparam logic [7:0] PIN_SYNC_RESET = 8'h00;
  localparam logic [BUS_W-1:0] READ_ZERO = 32'h00000000;

  // ==========================================================================
  // Pin positions of the alternate functions.
  // ==========================================================================
  localparam int PIN_TIMER_IN_A = 0;
  localparam int PIN_TIMER_IN_B = 1;
  localparam int PIN_TIMER_IN_C = 2;
  localparam int PIN_TIMER_OUT_A = 3;
  localparam int PIN_TIMER_IN_D = 4;
  localparam int PIN_TIMER_OUT_B = 5;
  localparam int PIN_KEY = 6;
  localparam int PIN_WIDE_OUT = 7;

endpackage : port_c_pkg

/* File: hdl/pin_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8 // Number of pins.
) (
  input wire logic core_clk, // System clock.
  input wire logic rstSync_n, // Synchronised reset, active low.
  input wire logic [WIDTH-1:0] pinRaw, // Asynchronous pin levels.
  output logic [WIDTH-1:0] pinLevel // Filtered pin levels.
);
  import port_c_pkg::*;

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] level_reg;

  // ==========================================================================
  // Synchroniser chain.
  // ==========================================================================
  // The first stage feeds only the second stage, keeping metastability contained.
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      stage1_reg <= WIDTH'(PIN_SYNC_RESET);
      stage2_reg <= WIDTH'(PIN_SYNC_RESET);
      stage3_reg <= WIDTH'(PIN_SYNC_RESET);
    end else begin
      stage1_reg <= pinRaw;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // A bit moves only where stages two and three agree, which rejects one-cycle glitches.
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      level_reg <= WIDTH'(PIN_SYNC_RESET);
    end else begin
      level_reg <= (level_reg & ~(stage2_reg ~^ stage3_reg)) | (stage3_reg & (stage2_reg ~^ stage3_reg));
    end
  end

  assign pinLevel = level_reg;

endmodule : pin_sync

/* File: hdl/port_c_gpio.sv */
// Eight-bit port C with direction, data latch and alternate-function routing.
`timescale 1ns/1ps
module port_c_gpio (
  input wire logic core_clk, // System clock, 50 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [port_c_pkg::ADDR_W-1:0] avs_address, // Avalon word address.
  input wire logic avs_read, // Avalon read request.
  input wire logic avs_write, // Avalon write request.
  input wire logic [port_c_pkg::BUS_W-1:0] avs_writedata, // Avalon write data.
  input wire logic [3:0] avs_byteenable, // Avalon byte enables.
  output logic [port_c_pkg::BUS_W-1:0] avs_readdata, // Avalon read data.
  output logic avs_waitrequest, // Avalon wait request.
  input wire logic [port_c_pkg::PORT_W-1:0] padIn, // Pin input levels.
  output logic [port_c_pkg::PORT_W-1:0] padOut, // Pin output levels.
  output logic [port_c_pkg::PORT_W-1:0] padOe, // Pin output enables, high drives.
  output logic keyPullup, // Pull-up enable for pin 6.
  input wire logic key_pullup_enable, // Pull-up enable from key wake-up control.
  input wire logic key_wakeup_pin_setting, // Key input enabled for pin 6.
  input wire logic eight_bit_timer_out_a, // Timer output routed to pin 3.
  input wire logic eight_bit_timer_out_b, // Timer output routed to pin 5.
  input wire logic eight_bit_timer_out_c, // Timer output routed to pin 7.
  output logic eight_bit_timer_in_a, // Timer input from pin 0.
  output logic eight_bit_timer_in_b, // Timer input from pin 1.
  output logic eight_bit_timer_in_c, // Timer input from pin 2.
  output logic eight_bit_timer_in_d, // Timer input from pin 4.
  output logic ext_interrupt_a, // Interrupt input from pin 0.
  output logic ext_interrupt_b, // Interrupt input from pin 1.
  output logic ext_interrupt_c, // Interrupt input from pin 2.
  output logic wide_timer_in_0, // Wide timer input from pin 6.
  output logic wide_timer_in_1, // Wide timer input from pin 7.
  output logic key_input_line // Key input from pin 6.
);
  import port_c_pkg::*;

  // ==========================================================================
  // Declarations.
  // ==========================================================================
  logic rstMeta_reg;
  logic rstSync_n;
  logic ack_reg;
  logic ackNext;
  logic request;
  logic accept;
  logic [7:0] latch_reg;
  logic [7:0] direction_reg;
  logic [7:0] fsel_reg;
  logic [7:0] pinLevel;
  logic [7:0] dataView;
  logic [7:0] padOut_reg;
  logic [7:0] padOutNext;
  logic [BUS_W-1:0] readdata_reg;
  logic [BUS_W-1:0] readdataNext;
  logic pullup_reg;
  logic [9:0] periphIn_reg;
  logic [9:0] periphInNext;

  // The pin routing below is hard-wired to eight pins.
  if (PORT_W != 8) begin : g_width_check
    $error("port_c_gpio supports exactly eight pins");
  end

  // Input pin is routed when selected and in input mode.
  function automatic logic routeIn(input logic sel, input logic dir, input logic lvl);
    routeIn = sel & ~dir & lvl;
  endfunction : routeIn

  // ==========================================================================
  // Reset release.
  // ==========================================================================
  // Reset asserts at once and releases after two clean edges.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_n <= rstMeta_reg;
    end
  end

  // ==========================================================================
  // Pin input synchroniser.
  // ==========================================================================
  pin_sync #(
    .WIDTH(PORT_W)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rstSync_n(rstSync_n),
    .pinRaw(padIn),
    .pinLevel(pinLevel)
  );

  // ==========================================================================
  // Avalon slave handshake.
  // ==========================================================================
  // Each access waits one cycle so that read data come from a register.
  assign request = avs_read | avs_write;
  assign ackNext = request & ~ack_reg;
  assign accept = request & ack_reg;
  assign avs_waitrequest = request & ~ack_reg;

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= ackNext;
    end
  end

  assign dataView = (direction_reg & latch_reg) | (~direction_reg & pinLevel);

  // Write-only registers and unmapped addresses read as zero.
  always_comb begin
    readdataNext = READ_ZERO;
    if (avs_address == PORT_C_DATA_IDX) begin
      readdataNext = {24'h000000, dataView};
    end else begin
      readdataNext = READ_ZERO;
    end
  end

  // Read data are captured while the slave still waits and stand at the accept edge.
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      readdata_reg <= READ_ZERO;
    end else if (ackNext && avs_read) begin
      readdata_reg <= readdataNext;
    end
  end

  assign avs_readdata = readdata_reg;

  // ==========================================================================
  // Registers.
  // ==========================================================================
  // Latch reset high.
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      latch_reg <= DATA_LATCH_RESET;
    end else if (accept && avs_write && avs_byteenable[0] && avs_address == PORT_C_DATA_IDX) begin
      latch_reg <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      direction_reg <= DIRECTION_RESET;
    end else if (accept && avs_write && avs_byteenable[0]
                 && avs_address == PORT_C_DIRECTION_IDX) begin
      direction_reg <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      fsel_reg <= FUNCTION_SELECT_RESET;
    end else if (accept && avs_write && avs_byteenable[0]
                 && avs_address == PORT_C_FUNCTION_SELECT_IDX) begin
      fsel_reg <= avs_writedata[7:0];
    end
  end

  // ==========================================================================
  // Output routing.
  // ==========================================================================
  // Output mux.
  always_comb begin
    padOutNext = latch_reg;
    if (fsel_reg[PIN_TIMER_OUT_A] && direction_reg[PIN_TIMER_OUT_A]) begin
      padOutNext[PIN_TIMER_OUT_A] = eight_bit_timer_out_a;
    end
    if (fsel_reg[PIN_TIMER_OUT_B] && direction_reg[PIN_TIMER_OUT_B]) begin
      padOutNext[PIN_TIMER_OUT_B] = eight_bit_timer_out_b;
    end
    if (fsel_reg[PIN_WIDE_OUT] && direction_reg[PIN_WIDE_OUT]) begin
      padOutNext[PIN_WIDE_OUT] = eight_bit_timer_out_c;
    end
  end

  // Pin data are registered, so timer edges reach the pins one cycle late.
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      padOut_reg <= DATA_LATCH_RESET;
    end else begin
      padOut_reg <= padOutNext;
    end
  end

  assign padOut = padOut_reg;
  assign padOe = direction_reg;

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pullup_reg <= 1'b0;
    end else begin
      pullup_reg <= key_pullup_enable & key_wakeup_pin_setting & fsel_reg[PIN_KEY];
    end
  end

  assign keyPullup = pullup_reg;

  // ==========================================================================
  // Peripheral input routing.
  // ==========================================================================
  // Input routes.
  // Shared inputs both see the pin when selected; interrupts on pins 0 to 2 need no select. The receiving module decides which one listens.
  always_comb begin
    periphInNext = 10'h000;
    periphInNext[0] = routeIn(fsel_reg[0], direction_reg[0], pinLevel[0]);
    periphInNext[1] = routeIn(fsel_reg[1], direction_reg[1], pinLevel[1]);
    periphInNext[2] = routeIn(fsel_reg[2], direction_reg[2], pinLevel[2]);
    periphInNext[3] = routeIn(fsel_reg[4], direction_reg[4], pinLevel[4]);
    periphInNext[4] = routeIn(1'b1, direction_reg[0], pinLevel[0]);
    periphInNext[5] = routeIn(1'b1, direction_reg[1], pinLevel[1]);
    periphInNext[6] = routeIn(1'b1, direction_reg[2], pinLevel[2]);
    periphInNext[7] = routeIn(fsel_reg[6], direction_reg[6], pinLevel[6]);
    periphInNext[8] = routeIn(fsel_reg[7], direction_reg[7], pinLevel[7]);
    periphInNext[9] = routeIn(fsel_reg[6], direction_reg[6], pinLevel[6]);
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      periphIn_reg <= 10'h000;
    end else begin
      periphIn_reg <= periphInNext;
    end
  end

  assign eight_bit_timer_in_a = periphIn_reg[0];
  assign eight_bit_timer_in_b = periphIn_reg[1];
  assign eight_bit_timer_in_c = periphIn_reg[2];
  assign eight_bit_timer_in_d = periphIn_reg[3];
  assign ext_interrupt_a = periphIn_reg[4];
  assign ext_interrupt_b = periphIn_reg[5];
  assign ext_interrupt_c = periphIn_reg[6];
  assign wide_timer_in_0 = periphIn_reg[7];
  assign wide_timer_in_1 = periphIn_reg[8];
  assign key_input_line = periphIn_reg[9];

  // ==========================================================================
  // Assertions.
  // ==========================================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstSync_n);

  sequence s_dirWrite;
    accept && avs_write && avs_byteenable[0] && avs_address == PORT_C_DIRECTION_IDX;
  endsequence

  sequence s_dataReadStart;
    ackNext && avs_read && avs_address == PORT_C_DATA_IDX;
  endsequence

  property p_dirWrite;
    s_dirWrite |=> padOe == $past(avs_writedata[7:0]);
  endproperty
  a_dirWrite: assert property (p_dirWrite) else $error("direction write not on enables");

  property p_resetCtl;
    $rose(rstSync_n) |-> direction_reg == 8'h00 && fsel_reg == 8'h00;
  endproperty
  a_resetCtl: assert property (p_resetCtl) else $error("control not cleared by reset");

  property p_resetLatch;
    $rose(rstSync_n) |-> latch_reg == 8'hFF && padOe == 8'h00;
  endproperty
  a_resetLatch: assert property (p_resetLatch) else $error("latch not set by reset");

  property p_portPin;
    !fsel_reg[PIN_TIMER_OUT_B] |=> padOut[PIN_TIMER_OUT_B] == $past(latch_reg[PIN_TIMER_OUT_B]);
  endproperty
  a_portPin: assert property (p_portPin) else $error("port pin not from latch");

  property p_intIn;
    !direction_reg[0] |=> ext_interrupt_a == $past(pinLevel[0])
      && eight_bit_timer_in_a == $past(fsel_reg[0] & pinLevel[0]);
  endproperty
  a_intIn: assert property (p_intIn) else $error("pin 0 input routing wrong");

  property p_timerOut;
    fsel_reg[PIN_TIMER_OUT_A] && direction_reg[PIN_TIMER_OUT_A]
      |=> padOut[PIN_TIMER_OUT_A] == $past(eight_bit_timer_out_a);
  endproperty
  a_timerOut: assert property (p_timerOut) else $error("pin 3 timer output wrong");

  property p_keyIn;
    fsel_reg[PIN_KEY] && !direction_reg[PIN_KEY]
      |=> key_input_line == $past(pinLevel[PIN_KEY]) && wide_timer_in_0 == key_input_line;
  endproperty
  a_keyIn: assert property (p_keyIn) else $error("pin 6 input routing wrong");

  property p_timerInD;
    fsel_reg[PIN_TIMER_IN_D] && !direction_reg[PIN_TIMER_IN_D]
      |=> eight_bit_timer_in_d == $past(pinLevel[PIN_TIMER_IN_D]);
  endproperty
  a_timerInD: assert property (p_timerInD) else $error("pin 4 timer input wrong");

  property p_pin7;
    fsel_reg[PIN_WIDE_OUT] |=> ($past(direction_reg[PIN_WIDE_OUT])
      ? (padOut[PIN_WIDE_OUT] == $past(eight_bit_timer_out_c) && !wide_timer_in_1)
      : wide_timer_in_1 == $past(pinLevel[PIN_WIDE_OUT]));
  endproperty
  a_pin7: assert property (p_pin7) else $error("pin 7 routing wrong");

  property p_pullupOn;
    key_pullup_enable && key_wakeup_pin_setting && fsel_reg[PIN_KEY] |=> keyPullup;
  endproperty
  a_pullupOn: assert property (p_pullupOn) else $error("pin 6 pull-up not enabled");

  property p_pullupOff;
    !fsel_reg[PIN_KEY] |=> !keyPullup;
  endproperty
  a_pullupOff: assert property (p_pullupOff) else $error("pin 6 pull-up on as port");

  property p_dataRead;
    s_dataReadStart |=> !avs_waitrequest
      && avs_readdata[7:0] == $past((direction_reg & latch_reg) | (~direction_reg & pinLevel));
  endproperty
  a_dataRead: assert property (p_dataRead) else $error("data read value wrong");

endmodule : port_c_gpio

/* File: verification/port_c_far_side.sv */
// Far-side model: the package pins and the on-chip timers beside port C.
`timescale 1ns/1ps
module port_c_far_side (
  input wire logic [port_c_pkg::PORT_W-1:0] extLevel, // Level the board drives.
  input wire logic [2:0] timerDrive, // Timer output levels a, b, c.
  input wire logic [port_c_pkg::PORT_W-1:0] padOut, // Block drive data.
  input wire logic [port_c_pkg::PORT_W-1:0] padOe, // Block drive enables.
  output logic [port_c_pkg::PORT_W-1:0] padIn, // Resolved pin levels.
  output logic timerOutA, // Timer output for pin 3.
  output logic timerOutB, // Timer output for pin 5.
  output logic timerOutC // Timer output for pin 7.
);
  import port_c_pkg::*;
  // ==========================================================================
  // Pin resolution
  // ==========================================================================
  // wire level
  // The board yields where the block drives, so no contention reaches padIn.
  assign padIn = (padOe & padOut) | (~padOe & extLevel);
  // timer outputs
  // Each timer output follows its bit of timerDrive, a for pin 3, b for pin 5 and c for pin 7.
  assign timerOutA = timerDrive[0];
  assign timerOutB = timerDrive[1];
  assign timerOutC = timerDrive[2];
endmodule : port_c_far_side

/* File: verification/test_eight_bit_port_c_gpio_mux.sv */
// Self-checking testbench of the port C block.
`timescale 1ns/1ps
module test_eight_bit_port_c_gpio_mux;
  import port_c_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [BUS_W-1:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [BUS_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] padIn, padOut, padOe, extLevel = 8'h3C;
  logic [2:0] timerDrive = 3'h0;
  logic keyPullup, pullEn = 1'b0, keySet = 1'b0;
  logic tOutA, tOutB, tOutC;
  logic [9:0] inVec;
  logic [31:0] rd;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  port_c_gpio u_port_c_gpio (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .keyPullup(keyPullup), .key_pullup_enable(pullEn), .key_wakeup_pin_setting(keySet),
    .eight_bit_timer_out_a(tOutA), .eight_bit_timer_out_b(tOutB),
    .eight_bit_timer_out_c(tOutC), .eight_bit_timer_in_a(inVec[0]),
    .eight_bit_timer_in_b(inVec[1]), .eight_bit_timer_in_c(inVec[2]),
    .eight_bit_timer_in_d(inVec[3]), .wide_timer_in_0(inVec[4]),
    .wide_timer_in_1(inVec[5]), .key_input_line(inVec[6]), .ext_interrupt_a(inVec[7]),
    .ext_interrupt_b(inVec[8]), .ext_interrupt_c(inVec[9]));

  port_c_far_side u_port_c_far_side (.extLevel(extLevel), .timerDrive(timerDrive),
    .padOut(padOut), .padOe(padOe), .padIn(padIn), .timerOutA(tOutA), .timerOutB(tOutB),
    .timerOutC(tOutC));

  // ==========================================================================
  // Clock, timeout and shared tasks
  // ==========================================================================
  initial begin
    forever #10 core_clk = ~core_clk;
  end

  // A hang is cut after far more cycles than the whole sequence needs.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count = fail_count + 1;
      close_out();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Waitrequest and read data are taken at the rising edge, as the slave's flops see them.
  // One idle edge follows each access so that a second call never re-raises a strobe at once.
  task automatic bus_cycle(input logic wr, input logic [31:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask : bus_cycle

  task automatic bus_read(input logic [31:0] a, input logic [7:0] exp, input string what);
    bus_cycle(1'b0, a, 8'h00);
    check(what, rd, {24'h000000, exp});
  endtask : bus_read

  // Pins need five edges through the filter; eight leaves margin.
  task automatic settle();
    repeat (8) @(posedge core_clk);
  endtask : settle

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    check("padOe", padOe, 8'h00);
    check("padOut", padOut, 8'hFF);
    check("keyPullup", keyPullup, 1'b0);
    bus_read(PORT_C_DATA_IDX, 8'h3C, "data in");
    bus_read(PORT_C_DIRECTION_IDX, 8'h00, "dir rd");
    bus_read(PORT_C_FUNCTION_SELECT_IDX, 8'h00, "fsel rd");
    bus_read(PORT_C_DATA_IDX + 32'h00000010, 8'h00, "unmapped");
  endtask : t_reset

  task automatic t_dir_data();
    bus_cycle(1'b1, PORT_C_DATA_IDX, 8'hA5);
    bus_cycle(1'b1, PORT_C_DIRECTION_IDX, 8'h0F);
    avs_byteenable <= 4'hE;
    bus_cycle(1'b1, PORT_C_DIRECTION_IDX, 8'hFF);
    avs_byteenable <= 4'hF;
    settle();
    check("padOe", padOe, 8'h0F);
    check("padOut", padOut, 8'hA5);
    bus_read(PORT_C_DATA_IDX, 8'h35, "data mix");
  endtask : t_dir_data

  task automatic t_alt_out();
    bus_cycle(1'b1, PORT_C_DATA_IDX, 8'h57);
    bus_cycle(1'b1, PORT_C_DIRECTION_IDX, 8'hA8);
    bus_cycle(1'b1, PORT_C_FUNCTION_SELECT_IDX, 8'hA8);
    timerDrive <= 3'b101;
    settle();
    check("padOut t", padOut, 8'hDF);
    timerDrive <= 3'b010;
    settle();
    check("padOut t2", padOut, 8'h77);
    bus_cycle(1'b1, PORT_C_FUNCTION_SELECT_IDX, 8'h00);
    settle();
    check("padOut port", padOut, 8'h57);
  endtask : t_alt_out

  task automatic t_alt_in();
    extLevel <= 8'hFF;
    bus_cycle(1'b1, PORT_C_DIRECTION_IDX, 8'h00);
    settle();
    check("inputs port", inVec, 10'h380);
    bus_cycle(1'b1, PORT_C_FUNCTION_SELECT_IDX, 8'hFF);
    settle();
    check("inputs alt", inVec, 10'h3FF);
    extLevel <= 8'h00;
    settle();
    check("inputs low", inVec, 10'h000);
    extLevel <= 8'hFF;
    bus_cycle(1'b1, PORT_C_DIRECTION_IDX, 8'hFF);
    settle();
    check("inputs out", inVec, 10'h000);
  endtask : t_alt_in

  task automatic t_pullup();
    pullEn <= 1'b1;
    keySet <= 1'b1;
    bus_cycle(1'b1, PORT_C_FUNCTION_SELECT_IDX, 8'h00);
    settle();
    check("pull port", keyPullup, 1'b0);
    bus_cycle(1'b1, PORT_C_FUNCTION_SELECT_IDX, 8'h40);
    settle();
    check("pull on", keyPullup, 1'b1);
    pullEn <= 1'b0;
    settle();
    check("pull pe", keyPullup, 1'b0);
    pullEn <= 1'b1;
    keySet <= 1'b0;
    settle();
    check("pull key", keyPullup, 1'b0);
  endtask : t_pullup

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    t_reset();
    t_dir_data();
    t_alt_out();
    t_alt_in();
    t_pullup();
    close_out();
  end
endmodule : test_eight_bit_port_c_gpio_mux
